// ==== apdib_params.svh ====
// Constants for the automatic power-down and input blocking block
// Summary of operation
// - Watch address strobe; when enabled and idle long enough, enter power-down.
// - In power-down block host address and data, deselect memories.
// - Unblocked changing logic inputs keep arrays awake, not memories.
// - Chip-select is active low; high puts memories and control block in standby.
// - Chip-select deselect blocks no signal and leaves logic arrays enabled.
// - Host writes blocking bits at run time; set bit blocks signal from arrays.
// - Configuration image blocks unused low address byte or control signals.
// - Fast-mode bit defaults on; setting it lets arrays enter standby.
// - Common clock input clocks output cell flip-flops and idle counter.
// - Port pin in strobe mode supplies the monitored address strobe.
// - Counter cleared while strobe pulses or disabled; power-down after 15 clocks.
// - Leave power-down on strobe pulse, chip-select returning low, or reset returning high.
// - Power-down enable sits at bit 1 of first power register.
// - In power-down data and peripheral pins float, others hold or undefined.
`ifndef APDIB_PARAMS_SVH
`define APDIB_PARAMS_SVH
`define APDIB_IDLE_CLOCKS      4'hF
`define APDIB_PM0_APD_EN_BIT   1
`define APDIB_PM0_FAST_OFF_BIT 3
`define APDIB_PM0_ARRCLK_BIT   4
`define APDIB_PM0_CELLCLK_BIT  5
`define APDIB_PM2_ADDR_BIT     0
`define APDIB_PM2_CTL0_BIT     2
`define APDIB_PM2_CTL1_BIT     3
`define APDIB_PM2_CTL2_BIT     4
`define APDIB_PM2_STROBE_BIT   5
`define APDIB_PM2_WRH_BIT      6
`define APDIB_PM_RESET         8'h00
`endif

// ==== apdib_pkg.sv ====
// Types for the automatic power-down and input blocking block
package apdib_pkg;
    typedef struct packed {
        logic [7:0]  addr_low;
        logic [15:0] addr_high_data;
        logic [2:0]  bus_control_inputs;
        logic        strobe;
        logic        write_enable_high_n;
        logic        common_clock_in;
    } apdib_bus_t;
    typedef enum logic [0:0] {APDIB_RUN, APDIB_DOWN} apdib_state_t;
endpackage

// ==== apdib_idle_counter.sv ====
// Idle counter for strobe activity
`timescale 1ns/10ps
`default_nettype none
`include "apdib_params.svh"
module apdib_idle_counter (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic enable,
    input  wire logic strobe,
    input  wire logic cfg_strobe_high,
    // Status
    output var  logic expired,
    output var  logic activity
);
    logic       strobe_q;
    logic [3:0] count;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            strobe_q <= 1'b0;
        else
            strobe_q <= strobe;
    end

    always_comb
    begin
        activity = strobe != strobe_q;
    end

    // Count clocks while strobe idle at inactive level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count <= 4'h0;
        else if (!enable || activity || strobe != cfg_strobe_high)
            count <= 4'h0;
        else if (count != `APDIB_IDLE_CLOCKS)
            count <= count + 4'h1;
    end

    always_comb
    begin
        expired = count == `APDIB_IDLE_CLOCKS;
    end
endmodule
`default_nettype wire

// ==== apdib_power_down.sv ====
// Automatic power-down and logic-array input blocking
`timescale 1ns/10ps
`default_nettype none
`include "apdib_params.svh"
module apdib_power_down (
    // Clock (common clock input pin) and reset
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                power_up,
    // Host register writes
    input  wire logic                power_mgmt_reg_first_we,
    input  wire logic                power_mgmt_reg_second_we,
    input  wire logic [7:0]          reg_wdata,
    // Configuration image
    input  wire logic                cfg_strobe_on_portd_pin0,
    input  wire logic                cfg_strobe_high_idle,
    input  wire logic                cfg_use_addr_low,
    input  wire logic                cfg_use_control,
    // Host bus
    input  wire apdib_pkg::apdib_bus_t host_bus,
    input  wire logic                portd_pin0,
    input  wire logic                chip_select_n,
    input  wire logic                reset_in_n,
    // Memory side
    output var  apdib_pkg::apdib_bus_t mem_bus,
    output var  logic                memory_select,
    output var  logic                control_register_block_select,
    // Logic array side
    output var  apdib_pkg::apdib_bus_t array_bus,
    output var  logic                array_fast_mode,
    output var  logic                cell_clock_enable,
    // Pins and status
    output var  logic                data_port_oe_n,
    output var  logic                power_down_active,
    output var  logic [7:0]          power_mgmt_reg_first,
    output var  logic [7:0]          power_mgmt_reg_second
);
    apdib_pkg::apdib_state_t state;
    apdib_pkg::apdib_bus_t   next_array_bus;
    logic                    strobe_src;
    logic                    expired;
    logic                    activity;
    logic                    reset_in_q;
    logic                    chip_select_q;
    logic                    wake;

    // ------------------------------------------------------------
    // Registers, cleared only by power-up
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge power_up)
    begin
        if (power_up)
            power_mgmt_reg_first <= `APDIB_PM_RESET;
        else if (power_mgmt_reg_first_we)
            power_mgmt_reg_first <= reg_wdata & 8'h3A;
    end

    always_ff @(posedge clk or posedge power_up)
    begin
        if (power_up)
            power_mgmt_reg_second <= `APDIB_PM_RESET;
        else if (power_mgmt_reg_second_we)
            power_mgmt_reg_second <= reg_wdata & 8'h7D;
    end

    // ------------------------------------------------------------
    // Idle detection
    // ------------------------------------------------------------
    always_comb
    begin
        strobe_src = cfg_strobe_on_portd_pin0 ? portd_pin0 : host_bus.strobe;
    end

    apdib_idle_counter u_idle (
        .clk             (clk),
        .rst             (rst),
        .enable          (power_mgmt_reg_first[`APDIB_PM0_APD_EN_BIT] && !wake),
        .strobe          (strobe_src),
        .cfg_strobe_high (cfg_strobe_high_idle),
        .expired         (expired),
        .activity        (activity)
    );

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reset_in_q <= 1'b1;
        else
            reset_in_q <= reset_in_n;
    end

    // Chip-select history, for its return low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            chip_select_q <= 1'b0;
        else
            chip_select_q <= chip_select_n;
    end

    // Wake events; the idle count restarts on them
    always_comb
    begin
        wake = state == apdib_pkg::APDIB_DOWN
               && (activity || (chip_select_q && !chip_select_n) || (reset_in_n && !reset_in_q));
    end

    // ------------------------------------------------------------
    // Power-down state
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state <= apdib_pkg::APDIB_RUN;
        else
            case (state)
                apdib_pkg::APDIB_RUN:
                    if (expired && power_mgmt_reg_first[`APDIB_PM0_APD_EN_BIT])
                        state <= apdib_pkg::APDIB_DOWN;
                apdib_pkg::APDIB_DOWN:
                    if (wake)
                        state <= apdib_pkg::APDIB_RUN;
                default:
                    state <= apdib_pkg::APDIB_RUN;
            endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            power_down_active <= 1'b0;
        else
            power_down_active <= state == apdib_pkg::APDIB_DOWN;
    end

    // ------------------------------------------------------------
    // Memory path
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_bus <= '0;
            memory_select <= 1'b0;
            control_register_block_select <= 1'b0;
        end
        else
        begin
            if (state != apdib_pkg::APDIB_DOWN)
                mem_bus <= host_bus;
            memory_select <= !chip_select_n && state != apdib_pkg::APDIB_DOWN;
            control_register_block_select <= !chip_select_n;
        end
    end

    // ------------------------------------------------------------
    // Logic array path; chip-select plays no part here
    // ------------------------------------------------------------
    always_comb
    begin
        next_array_bus = host_bus;
        if (state == apdib_pkg::APDIB_DOWN)
        begin
            next_array_bus.addr_low = array_bus.addr_low;
            next_array_bus.addr_high_data = array_bus.addr_high_data;
        end
        if (power_mgmt_reg_second[`APDIB_PM2_ADDR_BIT] || !cfg_use_addr_low)
            next_array_bus.addr_low = 8'h00;
        if (power_mgmt_reg_second[`APDIB_PM2_CTL0_BIT] || !cfg_use_control)
            next_array_bus.bus_control_inputs[0] = 1'b0;
        if (power_mgmt_reg_second[`APDIB_PM2_CTL1_BIT] || !cfg_use_control)
            next_array_bus.bus_control_inputs[1] = 1'b0;
        if (power_mgmt_reg_second[`APDIB_PM2_CTL2_BIT] || !cfg_use_control)
            next_array_bus.bus_control_inputs[2] = 1'b0;
        if (power_mgmt_reg_second[`APDIB_PM2_STROBE_BIT] || !cfg_use_control)
            next_array_bus.strobe = 1'b0;
        if (power_mgmt_reg_second[`APDIB_PM2_WRH_BIT] || !cfg_use_control)
            next_array_bus.write_enable_high_n = 1'b1;
        if (power_mgmt_reg_first[`APDIB_PM0_ARRCLK_BIT])
            next_array_bus.common_clock_in = 1'b0;
    end

    // Unblocked control, strobe and clock array inputs keep toggling in power-down; address and data hold
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            array_bus <= '0;
        else
            array_bus <= next_array_bus;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            array_fast_mode <= 1'b1;
            cell_clock_enable <= 1'b1;
            data_port_oe_n <= 1'b0;
        end
        else
        begin
            array_fast_mode <= !power_mgmt_reg_first[`APDIB_PM0_FAST_OFF_BIT];
            cell_clock_enable <= !power_mgmt_reg_first[`APDIB_PM0_CELLCLK_BIT];
            data_port_oe_n <= state == apdib_pkg::APDIB_DOWN;
        end
    end
endmodule
`default_nettype wire

// ==== apdib_assertions.sv ====
// Assertion checker for the power-down and blocking block
`timescale 1ns/10ps
`default_nettype none
module apdib_checker (
    // Clock, reset and inputs
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  power_mgmt_reg_first_we,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  cfg_strobe_on_portd_pin0,
    input wire logic                  cfg_strobe_high_idle,
    input wire logic                  cfg_use_addr_low,
    input wire apdib_pkg::apdib_bus_t host_bus,
    input wire logic                  portd_pin0,
    input wire logic                  chip_select_n,
    // Outputs
    input wire apdib_pkg::apdib_bus_t mem_bus,
    input wire apdib_pkg::apdib_bus_t array_bus,
    input wire logic                  memory_select,
    input wire logic                  control_register_block_select,
    input wire logic                  power_down_active,
    input wire logic [7:0]            power_mgmt_reg_first,
    input wire logic [7:0]            power_mgmt_reg_second
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic       strb;
    logic [4:0] idle;
    assign strb = cfg_strobe_on_portd_pin0 ? portd_pin0 : host_bus.strobe;
    // Idle run of the monitored strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            idle <= 5'h00;
        else if (!power_mgmt_reg_first[1] || strb != cfg_strobe_high_idle || power_down_active)
            idle <= 5'h00;
        else if (idle != 5'h1F)
            idle <= idle + 5'h01;
    end
    a_no_early_down: assert property ($rose(power_down_active) |-> $past(idle) >= 5'h0F)
        else $error("power-down before full idle run");
    a_down_in_time: assert property (idle == 5'h14 |-> power_down_active)
        else $error("power-down missing after idle run");
    a_strobe_wake: assert property (power_down_active && strb != cfg_strobe_high_idle
        |-> ##[1:3] !power_down_active) else $error("no wake on strobe");
    a_down_mem_off: assert property (power_down_active [*2] |-> !memory_select && $stable(mem_bus))
        else $error("memory not isolated in power-down");
    a_cs_standby: assert property (chip_select_n |=> !memory_select && !control_register_block_select)
        else $error("memory selected while chip-select high");
    a_addr_block: assert property ((power_mgmt_reg_second[0] || !cfg_use_addr_low) && !power_down_active
        |=> array_bus.addr_low == 8'h00) else $error("blocked address reached array");
    a_addr_pass: assert property (!power_mgmt_reg_second[0] && cfg_use_addr_low ##1 !power_down_active
        |-> array_bus.addr_low == $past(host_bus.addr_low)) else $error("address not passed to array");
    a_reg_write: assert property (power_mgmt_reg_first_we
        |=> power_mgmt_reg_first == ($past(reg_wdata) & 8'h3A)) else $error("first register write wrong");
    c_enter: cover property ($rose(power_down_active));
    c_wake: cover property ($fell(power_down_active));
    c_cs_high: cover property (chip_select_n && !power_down_active);
endmodule
bind apdib_power_down apdib_checker i_apdib_checker (.*);
`default_nettype wire

// ==== apdib_host_model.sv ====
// Host bus model driving address, data, control and strobe
`timescale 1ns/10ps
`default_nettype none
module apdib_host_model (
    // Clock and control
    input  wire logic                  clk,
    input  wire logic                  run,
    input  wire logic                  idle_hi,
    // Host bus
    output var  apdib_pkg::apdib_bus_t host_bus
);
    logic [7:0] step = 8'h00;
    initial host_bus = '0;
    always @(negedge clk)
    begin
        step <= step + 8'h01;
        host_bus.addr_low <= step ^ 8'h5A;
        host_bus.addr_high_data <= {step, ~step};
        host_bus.bus_control_inputs <= step[2:0];
        host_bus.write_enable_high_n <= step[3];
        host_bus.common_clock_in <= step[0];
        host_bus.strobe <= run ? ~host_bus.strobe : idle_hi; // Pulses or rests
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Testbench for the power-down and blocking block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst = 1'b1, power_up = 1'b1, run = 1'b1;
    logic power_mgmt_reg_first_we = 1'b0, power_mgmt_reg_second_we = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic cfg_strobe_on_portd_pin0 = 1'b0, cfg_strobe_high_idle = 1'b1;
    logic cfg_use_addr_low = 1'b1, cfg_use_control = 1'b1;
    logic portd_pin0 = 1'b0, chip_select_n = 1'b0, reset_in_n = 1'b1;
    apdib_pkg::apdib_bus_t host_bus, mem_bus, array_bus;
    logic memory_select, control_register_block_select, array_fast_mode, cell_clock_enable;
    logic data_port_oe_n, power_down_active;
    logic [7:0] power_mgmt_reg_first, power_mgmt_reg_second;
    int fail_count = 0, compares = 0, n;
    always #4 clk = ~clk;
    apdib_power_down i_apdib_power_down (.*);
    apdib_host_model i_apdib_host_model (.clk(clk), .run(run), .idle_hi(cfg_strobe_high_idle), .host_bus(host_bus));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic wr(input logic second, input logic [7:0] d);
        @(negedge clk);
        {power_mgmt_reg_second_we, power_mgmt_reg_first_we, reg_wdata} = {second, !second, d};
        @(negedge clk);
        {power_mgmt_reg_second_we, power_mgmt_reg_first_we} = 2'h0;
        tick(1);
    endtask
    task automatic wait_down(output int cyc);
        cyc = 0;
        while (power_down_active !== 1'b1 && cyc < 40)
        begin
            tick(1);
            cyc++;
        end
    endtask
    task automatic give_verdict;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #20000;
        fail_count++;
        give_verdict();
    end
    initial
    begin
        repeat (2) @(negedge clk);
        {rst, power_up, run} = 3'h0;
        tick(25);
        chk("pd_disabled", 1'b0, power_down_active);
        chk("reg_first", 8'h00, power_mgmt_reg_first);
        chk("fast", 1'b1, array_fast_mode);
        run = 1'b1;
        wr(0, 8'hFF);
        chk("reg_first", 8'h3A, power_mgmt_reg_first);
        chk("fast", 1'b0, array_fast_mode);
        chk("cell_clk", 1'b0, cell_clock_enable);
        wr(1, 8'hFF);
        chk("reg_second", 8'h7D, power_mgmt_reg_second);
        chk("addr_blk", 8'h00, array_bus.addr_low);
        chk("ctl_blk", 3'h0, array_bus.bus_control_inputs);
        wr(1, 8'h00);
        chk("addr_pass", host_bus.addr_low, array_bus.addr_low);
        @(negedge clk);
        {cfg_use_addr_low, cfg_use_control} = 2'h0;
        tick(1);
        chk("cfg_addr", 8'h00, array_bus.addr_low);
        chk("cfg_ctl", 3'h0, array_bus.bus_control_inputs);
        @(negedge clk);
        {cfg_use_addr_low, cfg_use_control, chip_select_n} = 3'h7;
        tick(1);
        chk("mem_sel", 1'b0, memory_select);
        chk("ctl_sel", 1'b0, control_register_block_select);
        chk("cs_ctl", host_bus.bus_control_inputs, array_bus.bus_control_inputs);
        @(negedge clk);
        chip_select_n = 1'b0;
        tick(1);
        chk("mem_sel", 1'b1, memory_select);
        wr(0, 8'h02);
        for (int p = 0; p < 2; p++)
        begin
            @(negedge clk);
            {cfg_strobe_high_idle, run} = {p[0], 1'b0};
            wait_down(n);
            chk("entry", 1'b1, n >= 15 && n <= 19);
            chk("mem_off", 1'b0, memory_select);
            chk("data_float", 1'b1, data_port_oe_n);
            @(negedge clk);
            run = 1'b1;
            tick(4);
            chk("wake_strobe", 1'b0, power_down_active);
        end
        @(negedge clk);
        run = 1'b0;
        tick(10);
        @(negedge clk);
        run = 1'b1;
        @(negedge clk);
        run = 1'b0;
        wait_down(n);
        chk("restart", 1'b1, n >= 12 && power_down_active);
        @(negedge clk);
        reset_in_n = 1'b0;
        @(negedge clk);
        reset_in_n = 1'b1;
        tick(3);
        chk("wake_rst", 1'b0, power_down_active);
        wait_down(n);
        @(negedge clk);
        chip_select_n = 1'b1;
        @(negedge clk);
        chip_select_n = 1'b0;
        tick(3);
        chk("wake_cs", 1'b0, power_down_active);
        @(negedge clk);
        cfg_strobe_on_portd_pin0 = 1'b1;
        repeat (25) @(negedge clk) portd_pin0 = ~portd_pin0;
        chk("portd_busy", 1'b0, power_down_active);
        wait_down(n);
        chk("portd_idle", 1'b1, power_down_active);
        give_verdict();
    end
endmodule
`default_nettype wire
